/* File: verilog/acm_params.svh */
/*
 * constants of the converter mode and status control: timing, register
 * addresses, field positions and reset values.
 * assumes a single 10 MHz system clock.
 */
`ifndef ACM_PARAMS_SVH
`define ACM_PARAMS_SVH

// clock and timing
`define ACM_CLK_PERIOD_NS   100
`define ACM_BOOT_TIME_NS    20000
`define ACM_STARTUP_TIME_NS 100000
`define ACM_BOOT_CYCLES \
    ((`ACM_BOOT_TIME_NS + `ACM_CLK_PERIOD_NS - 1) / `ACM_CLK_PERIOD_NS)
`define ACM_STARTUP_CYCLES \
    ((`ACM_STARTUP_TIME_NS + `ACM_CLK_PERIOD_NS - 1) / `ACM_CLK_PERIOD_NS)

// register addresses on the serial port
`define ACM_ADDR_CTRL   4'h0
`define ACM_ADDR_RESULT 4'h1
`define ACM_ADDR_EXC    4'h2

// control word fields
`define ACM_NEG_LSB  12
`define ACM_POS_LSB  8
`define ACM_CNT_LSB  6
`define ACM_RDY_BIT  5
`define ACM_OV_BIT   4
`define ACM_MODE_LSB 0

// excitation configuration fields
`define ACM_B_SLP_BIT   15
`define ACM_B_CUR_LSB   12
`define ACM_B_EN_BIT    11
`define ACM_B_ROUTE_LSB 8
`define ACM_A_SLP_BIT   7
`define ACM_A_CUR_LSB   4
`define ACM_A_EN_BIT    3
`define ACM_A_ROUTE_LSB 0
`define ACM_EXC_MASK    16'hBFBF

// reset values
`define ACM_NEG_RESET  4'h4
`define ACM_POS_RESET  4'h0
`define ACM_CNT_RESET  2'h0
`define ACM_RDY_RESET  1'b1
`define ACM_OV_RESET   1'b0
`define ACM_EXC_RESET  16'h0000

`endif

/* File: verilog/acm_pkg.sv */
/*
 * types and helper functions of the converter mode and status control.
 * assumes acm_params.svh is on the include path.
 */
`include "acm_params.svh"

package acm_pkg;

    typedef enum logic [3:0] {
        MODE_IDLE        = 4'h0,
        MODE_SLEEP       = 4'h1,
        MODE_SINGLE      = 4'h2,
        MODE_CONT        = 4'h3,
        MODE_CHOPPED_CONVERSION_SINGLE = 4'h4,
        MODE_CHOPPED_CONVERSION_CONT   = 4'h5,
        MODE_IEX_SINGLE  = 4'h6,
        MODE_IEX_CONT    = 4'h7,
        MODE_CAL_OFFSET  = 4'hC,
        MODE_CAL_GAIN    = 4'hD,
        MODE_BOOT        = 4'hF
    } acm_mode_t;

    typedef enum logic [3:0] {
        INPUT_ONE_POS = 4'h0, INPUT_ONE_NEG = 4'h1,
        INPUT_TWO_POS = 4'h2, INPUT_TWO_NEG = 4'h3,
        INPUT_THREE_POS = 4'h4, INPUT_THREE_NEG = 4'h5,
        INPUT_FOUR_POS = 4'h6, INPUT_FOUR_NEG = 4'h7,
        INTERNAL_REFERENCE = 4'h8, ANALOG_NEG_SUPPLY = 4'h9,
        REFERENCE_POS_PIN = 4'hA, REFERENCE_NEG_PIN = 4'hB,
        TEMP_NODE_POS = 4'hC, TEMP_NODE_NEG = 4'hD,
        ANALOG_POS_SUPPLY = 4'hE, COMMON_MODE_NODE = 4'hF
    } acm_input_t;

    typedef enum logic [2:0] {
        OP_BOOT  = 3'b000,
        OP_IDLE  = 3'b001,
        OP_SLEEP = 3'b010,
        OP_WAKE  = 3'b011,
        OP_CONV  = 3'b100
    } acm_op_t;

    typedef struct packed {
        logic [1:0]  sck_s;
        logic [1:0]  cs_s;
        logic [1:0]  sdi_s;
        logic        sck_d;
        logic [5:0]  bit_cnt;
        logic [7:0]  cmd;
        logic [23:0] shift;
        logic        req_valid;
        logic        wr_valid;
    } acm_serial_t;

    typedef struct packed {
        acm_op_t     op;
        acm_mode_t   mode;
        logic [11:0] timer;
        logic [1:0]  phase;
        logic        chopped_conversion_phase;
        logic        start;
        logic        pwr_dn;
        logic [3:0]  neg_sel;
        logic [3:0]  pos_sel;
        logic [1:0]  rdy_cnt;
        logic        rdy_n;
        logic        ov;
        logic [23:0] result;
        logic [15:0] exc;
        logic        a_on;
        logic [1:0]  a_cur;
        logic [2:0]  a_route;
        logic        b_on;
        logic [1:0]  b_cur;
        logic [2:0]  b_route;
    } acm_core_t;

    // data bytes carried by a register after the command byte
    function automatic logic [1:0] reg_bytes(input logic [3:0] addr,
                                             input logic       wide);
        reg_bytes = (wide && (addr == 4'h1 || addr >= 4'h8)) ? 2'd3 : 2'd2;
    endfunction : reg_bytes

    // codes the host may write into the mode field
    function automatic logic mode_legal(input logic [3:0] m);
        mode_legal = (m <= 4'h7) || m == 4'hC || m == 4'hD;
    endfunction : mode_legal

    // conversion phases that make one result
    function automatic logic [1:0] chopped_conversion_phases(input acm_mode_t m);
        case (m)
            MODE_CHOPPED_CONVERSION_SINGLE, MODE_IEX_SINGLE: chopped_conversion_phases = 2'd2;
            MODE_CHOPPED_CONVERSION_CONT, MODE_IEX_CONT:     chopped_conversion_phases = 2'd3;
            default:                           chopped_conversion_phases = 2'd1;
        endcase
    endfunction : chopped_conversion_phases

    // places a raw 24-bit result in the register format of the variant
    function automatic logic [23:0] fmt_result(input logic [23:0] d,
                                               input int          res);
        if (res == 16) begin
            fmt_result = {8'h00, d[23:8]};
        end else if (res == 20) begin
            fmt_result = {d[23:4], 4'h0};
        end else begin
            fmt_result = d;
        end
    endfunction : fmt_result

endpackage : acm_pkg

/* File: verilog/acm_reg_if.sv */
/*
 * register request carrier between the serial front end and the core.
 * assumes both ends run on clk_sys.
 */
`timescale 1ns/1ps

interface acm_reg_if;
    logic        req_valid;
    logic        req_read;
    logic [3:0]  req_addr;
    logic [23:0] rd_data;
    logic        wr_valid;
    logic [3:0]  wr_addr;
    logic [23:0] wr_data;

    modport serial (output req_valid, req_read, req_addr,
                    output wr_valid, wr_addr, wr_data, input rd_data);
    modport core   (input req_valid, req_read, req_addr,
                    input wr_valid, wr_addr, wr_data, output rd_data);
endinterface : acm_reg_if

/* File: verilog/acm_spi_slave.sv */
/*
 * serial register port: oversamples sck, cs_n and sdi, collects the
 * command byte and data bytes msb first, issues read and write requests.
 * assumes sck runs at most at clk_sys / 10.
 */
`timescale 1ns/1ps

module acm_spi_slave #(
    parameter logic WIDE = 1'b1
) (
    input  logic     clk_sys,
    input  logic     rst_n,
    input  logic     sck,
    input  logic     cs_n,
    input  logic     sdi,
    output logic     sdo,
    output logic     sdo_oe,
    acm_reg_if.serial bus
);
    import acm_pkg::*;

    acm_serial_t s;
    acm_serial_t next_s;
    logic        fall;
    logic        rise;
    logic [1:0]  nbytes;
    logic [5:0]  last;

    localparam acm_serial_t SER_RESET = '{sck_s: 2'b00, cs_s: 2'b11,
        sdi_s: 2'b00, sck_d: 1'b0, bit_cnt: 6'h00, cmd: 8'h00,
        shift: 24'h00_0000, req_valid: 1'b0, wr_valid: 1'b0};

    // sample edges, shift command and data bits
    always_comb begin
        next_s           = s;
        next_s.sck_s     = {s.sck_s[0], sck};
        next_s.cs_s      = {s.cs_s[0], cs_n};
        next_s.sdi_s     = {s.sdi_s[0], sdi};
        next_s.sck_d     = s.sck_s[1];
        next_s.req_valid = 1'b0;
        next_s.wr_valid  = 1'b0;
        fall   = s.sck_d && !s.sck_s[1];
        rise   = !s.sck_d && s.sck_s[1];
        nbytes = reg_bytes(s.cmd[3:0], WIDE);
        last   = 6'({nbytes, 3'b000}) + 6'd8;
        if (s.cs_s[1]) begin
            next_s.bit_cnt = 6'h00;
        end else begin
            if (s.req_valid && s.cmd[7]) begin
                next_s.shift = (nbytes == 2'd2)
                    ? {bus.rd_data[15:0], 8'h00} : bus.rd_data;
            end
            if (fall && s.bit_cnt < 6'd8) begin
                next_s.cmd       = {s.cmd[6:0], s.sdi_s[1]};
                next_s.bit_cnt   = s.bit_cnt + 6'd1;
                next_s.req_valid = (s.bit_cnt == 6'd7);
            end else if (fall && s.bit_cnt < last) begin
                next_s.bit_cnt = s.bit_cnt + 6'd1;
                if (!s.cmd[7]) begin
                    next_s.shift    = {s.shift[22:0], s.sdi_s[1]};
                    next_s.wr_valid = (s.bit_cnt + 6'd1 == last);
                end
            end
            if (rise && s.cmd[7] && s.bit_cnt >= 6'd9 && s.bit_cnt < last)
            begin
                next_s.shift = {s.shift[22:0], 1'b0};
            end
        end
    end

    // state register
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            s <= SER_RESET;
        end else begin
            s <= next_s;
        end
    end

    // request and answer wiring
    assign bus.req_valid = s.req_valid;
    assign bus.req_read  = s.cmd[7];
    assign bus.req_addr  = s.cmd[3:0];
    assign bus.wr_valid  = s.wr_valid;
    assign bus.wr_addr   = s.cmd[3:0];
    assign bus.wr_data   = (nbytes == 2'd2) ? {8'h00, s.shift[15:0]}
                                            : s.shift;
    assign sdo           = s.shift[23];
    assign sdo_oe        = !s.cs_s[1];

    a_write_frame: assert property (@(posedge clk_sys) disable iff (!rst_n)
        s.wr_valid |-> s.bit_cnt == last && !s.cmd[7])
        else $error("write issued at wrong frame length");

endmodule : acm_spi_slave

/* File: verilog/acm_ctrl_top.sv */
/*
 * converter mode and status control: control word, result register,
 * excitation source configuration and the operation state machine.
 * assumes a conversion core on clk_sys that answers conv_start with a
 * one-cycle conv_done, and a host on the serial register port.
 */
`timescale 1ns/1ps
`include "acm_params.svh"

module acm_ctrl_top #(
    parameter int RESOLUTION = 24
) (
    input  logic               clk_sys,
    input  logic               rst_n,
    input  logic               spi_sck,
    input  logic               spi_cs_n,
    input  logic               spi_sdi,
    output logic               spi_sdo,
    output logic               spi_sdo_oe,
    input  logic               auto_sleep,
    input  logic               conv_done,
    input  logic [23:0]        conv_data,
    input  logic               conv_overflow,
    output logic               conv_start,
    output logic               conv_chopped_conversion,
    output logic               conv_use_offset,
    output logic               conv_cal_offset,
    output logic               conv_cal_gain,
    output logic               chopped_conversion_phase,
    output logic               analog_power_down,
    output acm_pkg::acm_input_t pos_input_select,
    output acm_pkg::acm_input_t neg_input_select,
    output logic               data_ready_n,
    output logic               src_a_on,
    output logic [1:0]         src_a_current,
    output logic [2:0]         src_a_route,
    output logic               src_b_on,
    output logic [1:0]         src_b_current,
    output logic [2:0]         src_b_route
);
    import acm_pkg::*;

    localparam logic WIDE = (RESOLUTION != 16);
    localparam logic [11:0] BOOT_LAST = 12'(`ACM_BOOT_CYCLES - 1);
    localparam logic [11:0] WAKE_LAST = 12'(`ACM_STARTUP_CYCLES - 1);

    localparam acm_core_t CORE_RESET = '{op: OP_BOOT, mode: MODE_BOOT,
        timer: BOOT_LAST, phase: 2'd0, chopped_conversion_phase: 1'b0, start: 1'b0,
        pwr_dn: 1'b1, neg_sel: `ACM_NEG_RESET, pos_sel: `ACM_POS_RESET,
        rdy_cnt: `ACM_CNT_RESET, rdy_n: `ACM_RDY_RESET,
        ov: `ACM_OV_RESET, result: 24'h00_0000, exc: `ACM_EXC_RESET,
        a_on: 1'b0, a_cur: 2'd0, a_route: 3'd0,
        b_on: 1'b0, b_cur: 2'd0, b_route: 3'd0};

    acm_reg_if bus ();

    acm_core_t   s;
    acm_core_t   next_s;
    logic        store;
    logic        read_clr;
    logic        ctrl_wr;
    logic        mode_act;
    logic        powered_down;
    logic        iex_swap;
    logic [3:0]  wmode;
    logic [1:0]  phase_next;
    logic [15:0] ctrl_word;

    // serial register port
    acm_spi_slave #(
        .WIDE (WIDE)
    ) u_serial (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .sck     (spi_sck),
        .cs_n    (spi_cs_n),
        .sdi     (spi_sdi),
        .sdo     (spi_sdo),
        .sdo_oe  (spi_sdo_oe),
        .bus     (bus.serial)
    );

    // control word as read back
    assign ctrl_word = {s.neg_sel, s.pos_sel, s.rdy_cnt, s.rdy_n, s.ov,
                        s.mode};

    // read data for the addressed register, unmapped reads give zero
    always_comb begin
        case (bus.req_addr)
            `ACM_ADDR_CTRL:   bus.rd_data = {8'h00, ctrl_word};
            `ACM_ADDR_RESULT: bus.rd_data = s.result;
            `ACM_ADDR_EXC:    bus.rd_data = {8'h00, s.exc};
            default:          bus.rd_data = 24'h00_0000;
        endcase
    end

    // next state: registers, mode machine, result capture
    always_comb begin
        next_s       = s;
        next_s.start = 1'b0;
        store        = 1'b0;
        read_clr     = bus.req_valid && bus.req_read
                       && bus.req_addr == `ACM_ADDR_RESULT;
        ctrl_wr      = bus.wr_valid && bus.wr_addr == `ACM_ADDR_CTRL;
        wmode        = bus.wr_data[`ACM_MODE_LSB +: 4];
        powered_down = s.op == OP_SLEEP
                       || (s.op == OP_IDLE && auto_sleep);
        phase_next   = s.phase + 2'd1;
        mode_act     = ctrl_wr && s.op != OP_BOOT && mode_legal(wmode)
                       && wmode != s.mode;
        iex_swap     = (s.mode == MODE_IEX_SINGLE
                        || s.mode == MODE_IEX_CONT) && s.chopped_conversion_phase;

        // selectors and excitation configuration
        if (ctrl_wr) begin
            next_s.neg_sel = bus.wr_data[`ACM_NEG_LSB +: 4];
            next_s.pos_sel = bus.wr_data[`ACM_POS_LSB +: 4];
        end
        if (bus.wr_valid && bus.wr_addr == `ACM_ADDR_EXC) begin
            next_s.exc = bus.wr_data[15:0] & `ACM_EXC_MASK;
        end

        // operation state machine
        case (s.op)
            OP_BOOT: begin
                if (s.timer == 12'd0) begin
                    next_s.op   = OP_IDLE;
                    next_s.mode = MODE_IDLE;
                end else begin
                    next_s.timer = s.timer - 12'd1;
                end
            end
            OP_IDLE, OP_SLEEP: begin
                next_s.phase = 2'd0;
            end
            OP_WAKE: begin
                if (s.timer == 12'd0) begin
                    next_s.op    = OP_CONV;
                    next_s.start = 1'b1;
                end else begin
                    next_s.timer = s.timer - 12'd1;
                end
            end
            OP_CONV: begin
                if (conv_done && phase_next == chopped_conversion_phases(s.mode)) begin
                    store = s.mode != MODE_CAL_OFFSET
                            && s.mode != MODE_CAL_GAIN;
                    next_s.phase      = 2'd0;
                    next_s.chopped_conversion_phase = 1'b0;
                    case (s.mode)
                        MODE_CONT, MODE_CHOPPED_CONVERSION_CONT, MODE_IEX_CONT: begin
                            next_s.start = 1'b1;
                        end
                        default: begin
                            next_s.op   = OP_IDLE;
                            next_s.mode = MODE_IDLE;
                        end
                    endcase
                end else if (conv_done) begin
                    next_s.phase      = phase_next;
                    next_s.chopped_conversion_phase = ~s.chopped_conversion_phase;
                    next_s.start      = 1'b1;
                end
            end
            default: begin
                next_s.op = OP_IDLE;
            end
        endcase

        // a host write of a new mode takes over the machine
        if (mode_act) begin
            next_s.mode       = acm_mode_t'(wmode);
            next_s.phase      = 2'd0;
            next_s.chopped_conversion_phase = 1'b0;
            if (wmode == MODE_IDLE) begin
                next_s.op = OP_IDLE;
            end else if (wmode == MODE_SLEEP) begin
                next_s.op = OP_SLEEP;
            end else if (powered_down) begin
                next_s.op    = OP_WAKE;
                next_s.timer = WAKE_LAST;
            end else begin
                next_s.op    = OP_CONV;
                next_s.start = 1'b1;
            end
        end

        // result capture wins over a read in the same cycle
        if (store) begin
            next_s.result  = fmt_result(conv_data, RESOLUTION);
            next_s.rdy_cnt = s.rdy_cnt + 2'd1;
            next_s.rdy_n   = 1'b0;
            next_s.ov      = conv_overflow;
        end else if (read_clr) begin
            next_s.rdy_n = 1'b1;
            next_s.ov    = 1'b0;
        end

        // excitation sources, routes swapped in the second chopped_conversion phase of the IEX modes only
        next_s.pwr_dn  = powered_down;
        next_s.a_cur   = s.exc[`ACM_A_CUR_LSB +: 2];
        next_s.b_cur   = s.exc[`ACM_B_CUR_LSB +: 2];
        next_s.a_route = iex_swap ? s.exc[`ACM_B_ROUTE_LSB +: 3]
                                  : s.exc[`ACM_A_ROUTE_LSB +: 3];
        next_s.b_route = iex_swap ? s.exc[`ACM_A_ROUTE_LSB +: 3]
                                  : s.exc[`ACM_B_ROUTE_LSB +: 3];
        next_s.a_on    = s.exc[`ACM_A_EN_BIT]
                         && !(powered_down && s.exc[`ACM_A_SLP_BIT]);
        next_s.b_on    = s.exc[`ACM_B_EN_BIT]
                         && !(powered_down && s.exc[`ACM_B_SLP_BIT]);
    end

    // state register
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            s <= CORE_RESET;
        end else begin
            s <= next_s;
        end
    end

    // outputs toward the conversion core and the analog block
    assign conv_start        = s.start;
    assign conv_chopped_conversion         = s.mode inside {MODE_CHOPPED_CONVERSION_SINGLE,
        MODE_CHOPPED_CONVERSION_CONT, MODE_IEX_SINGLE, MODE_IEX_CONT};
    assign conv_use_offset   = s.mode == MODE_SINGLE
                               || s.mode == MODE_CONT;
    assign conv_cal_offset   = s.mode == MODE_CAL_OFFSET;
    assign conv_cal_gain     = s.mode == MODE_CAL_GAIN;
    assign chopped_conversion_phase        = s.chopped_conversion_phase;
    assign analog_power_down = s.pwr_dn;
    assign pos_input_select  = acm_input_t'(s.pos_sel);
    assign neg_input_select  = acm_input_t'(s.neg_sel);
    assign data_ready_n      = s.rdy_n;
    assign src_a_on          = s.a_on;
    assign src_a_current     = s.a_cur;
    assign src_a_route       = s.a_route;
    assign src_b_on          = s.b_on;
    assign src_b_current     = s.b_cur;
    assign src_b_route       = s.b_route;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    a_ready_count: assert property (
        store |=> s.rdy_cnt == $past(s.rdy_cnt) + 2'd1)
        else $error("ready counter did not step on store");
    a_ready_low: assert property (store |=> !data_ready_n)
        else $error("ready flag not low after store");
    a_ready_release: assert property (
        read_clr && !store |=> data_ready_n && !s.ov)
        else $error("result read did not release flags");
    a_ovf_capture: assert property (
        store |=> s.ov == $past(conv_overflow))
        else $error("overflow flag not captured");
    a_single_done: assert property (
        store && s.mode == MODE_SINGLE && !mode_act
        |=> s.mode == MODE_IDLE && s.op == OP_IDLE)
        else $error("single conversion did not return to idle");
    a_cont_restart: assert property (
        store && s.mode == MODE_CONT && !mode_act |=> conv_start)
        else $error("continuous conversion did not restart");
    a_chopped_conversion_two: assert property (
        store && s.mode == MODE_CHOPPED_CONVERSION_SINGLE |-> s.phase == 2'd1)
        else $error("chopped single stored after wrong phase");
    a_chopped_conversion_three: assert property (
        store && s.mode == MODE_CHOPPED_CONVERSION_CONT |-> s.phase == 2'd2)
        else $error("chopped continuous stored after wrong phase");
    a_iex_swap: assert property (
        iex_swap |=> src_a_route == $past(s.exc[10:8]))
        else $error("excitation routes not swapped");
    a_boot_exit: assert property (
        s.op == OP_BOOT && s.timer == 12'd0 |=> s.mode == MODE_IDLE)
        else $error("boot did not end in idle");
    a_wake_wait: assert property (
        $rose(s.op == OP_WAKE) |-> !conv_start [*8])
        else $error("conversion started inside start-up delay");
    a_src_off: assert property (
        !s.exc[`ACM_A_EN_BIT] |=> !src_a_on)
        else $error("disabled source a still on");

endmodule : acm_ctrl_top

/* File: sim/acm_host_model.sv */
/* host model on the serial port: frames msb first.
   assumes clk_sys from the bench; sck idles low. */
`timescale 1ns/1ps
module acm_host_model (
    input  wire logic clk_sys,
    input  wire logic sdo,
    output logic      sck,
    output logic      cs_n,
    output logic      sdi
);
    // lines idle until a frame starts
    initial begin
        sck = 1'b0;
        cs_n = 1'b1;
        sdi = 1'b0;
    end
    // half sck period of five clocks, moved at falling clk
    task automatic half;
        repeat (5) @(negedge clk_sys);
    endtask : half
    // command byte then n data bytes; read bits caught on falling sck
    task automatic xfer(input logic [7:0] cmd, input logic [23:0] wd,
                        input int n, output logic [23:0] rd);
        logic [31:0] sh;
        sh = {cmd, wd << (8 * (3 - n))};
        rd = 24'h00_0000;
        cs_n = 1'b0;
        half();
        for (int i = 0; i < 8 * (n + 1); i++) begin
            sdi = sh[31 - i];
            sck = 1'b1;
            half();
            sck = 1'b0;
            if (i >= 8) rd = {rd[22:0], sdo};
            half();
        end
        cs_n = 1'b1;
        sdi = ~sdi;  // released line shows no stale bit
        half();
    endtask : xfer
endmodule : acm_host_model

/* File: sim/adc_mode_status_control_tb_top.sv */
/* bench: host model on the serial port, conversion core played here.
   assumes acm_pkg compiled first and a 10 MHz clk_sys. */
`timescale 1ns/1ps
module adc_mode_status_control_tb_top;
    import acm_pkg::*;
    logic        clk_sys, rst_n, sck, cs_n, sdi, sdo, auto_sleep;
    logic        conv_done, conv_overflow, conv_start, rdy_n, ov, cal;
    wire  [11:0] src;
    wire  [7:0]  sel;
    wire  [3:0]  dec;
    wire         pdn, oe, cph;
    logic [3:0]  seen;
    logic [3:0]  cm [3] = '{4'h5, 4'h3, 4'h7};
    logic [11:0] sx;
    logic [15:0] w, x;
    logic [23:0] conv_data, rd, d, last;
    logic [3:0]  md [6] = '{4'h2, 4'h4, 4'h6, 4'hC, 4'hD, 4'h2};
    int          errors, num_checks, seed, cnt, rc;

    acm_ctrl_top dut (.clk_sys(clk_sys), .rst_n(rst_n), .spi_sck(sck),
        .spi_cs_n(cs_n), .spi_sdi(sdi), .spi_sdo(sdo), .spi_sdo_oe(oe),
        .auto_sleep(auto_sleep), .conv_done(conv_done),
        .conv_data(conv_data), .conv_overflow(conv_overflow),
        .conv_start(conv_start), .conv_chopped_conversion(dec[3]),
        .conv_use_offset(dec[2]), .conv_cal_offset(dec[1]),
        .conv_cal_gain(dec[0]), .chopped_conversion_phase(cph),
        .analog_power_down(pdn), .pos_input_select(sel[3:0]),
        .neg_input_select(sel[7:4]),
        .data_ready_n(rdy_n), .src_a_on(src[11]), .src_a_current(src[10:9]),
        .src_a_route(src[8:6]), .src_b_on(src[5]),
        .src_b_current(src[4:3]), .src_b_route(src[2:0]));
    acm_host_model host (.clk_sys(clk_sys), .sdo(sdo), .sck(sck),
        .cs_n(cs_n), .sdi(sdi));

    task automatic chk(input string s, input logic [23:0] e,
                       input logic [23:0] g);
        num_checks++;
        if (g !== e) begin
            errors++;
            $display("Error %s expected %h seen %h", s, e, g);
        end
    endtask : chk
    task automatic conclude;
        if (errors == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : conclude
    // conversion core: answers each start with one done pulse
    task automatic core(input int ph, input logic [23:0] v, input logic o);
        for (int p = 0; p < ph; p++) begin
            cnt = 0;
            while (conv_start !== 1'b1 && cnt < 2000) begin
                @(negedge clk_sys);
                cnt++;
            end
            if (cnt >= 2000) begin
                errors++;
                conclude();
            end
            seen = dec;
            chk("chopped_conversion phase", p[0], cph);
            @(negedge clk_sys);
            conv_done = 1'b1;
            conv_data = v;
            conv_overflow = o;
            @(negedge clk_sys);
            conv_done = 1'b0;
        end
    endtask : core

    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    // main sequence: boot, conversions per mode, excitation config
    initial begin
        seed = 39901;
        rc = 0;
        rst_n = 1'b0;
        auto_sleep = 1'b0;
        conv_done = 1'b0;
        conv_overflow = 1'b0;
        conv_data = '0;
        last = '0;
        repeat (3) @(negedge clk_sys);
        rst_n = 1'b1;
        host.xfer(8'h80, '0, 2, rd);
        chk("boot ctrl", 24'h00_402F, rd);
        host.xfer(8'h80, '0, 2, rd);
        chk("idle ctrl", 24'h00_4020, rd);
        host.xfer(8'h85, '0, 2, rd);
        chk("unmapped", '0, rd);
        chk("sdo enable", 1'b0, oe);
        // mode table holds legal codes only
        for (int k = 0; k < 6; k++) begin
            d = 24'($random(seed));
            ov = d[0];
            w = {d[7:0], 4'h0, md[k]};
            cal = md[k][3];
            fork
                host.xfer(8'h00, {8'h00, w}, 2, rd);
                core((md[k] == 4'h4 || md[k] == 4'h6) ? 2 : 1, d, ov);
            join
            if (!cal) begin
                rc = (rc + 1) % 4;
                last = d;
            end
            chk("ready", cal, rdy_n);
            chk("decode", {md[k] == 4'h4 || md[k] == 4'h6,
                md[k] == 4'h2, cal & ~md[k][0], cal & md[k][0]}, seen);
            chk("selectors", w[15:8], sel);
            host.xfer(8'h80, '0, 2, rd);
            chk("ctrl", {w[15:8], rc[1:0], cal, ov & !cal, 4'h0}, rd);
            host.xfer(8'h81, '0, 3, rd);
            chk("result", last, rd);
            host.xfer(8'h80, '0, 2, rd);
            chk("ctrl rd", {w[15:8], rc[1:0], 2'b10, 4'h0}, rd);
        end
        for (int k = 0; k < 2; k++) begin
            x = 16'($random(seed)) & 16'hBFBF;
            auto_sleep = k[0];
            host.xfer(8'h02, {8'h00, x}, 2, rd);
            host.xfer(8'h82, '0, 2, rd);
            chk("exc cfg", x, rd);
            sx = {x[3] & !(k[0] & x[7]), x[5:4], x[2:0],
                  x[11] & !(k[0] & x[15]), x[13:12], x[10:8]};
            chk("sources", sx, src);
            chk("power down", k[0], pdn);
        end
        // sleep, then continuous modes woken from power down
        auto_sleep = 1'b0;
        host.xfer(8'h00, 24'h00_0001, 2, rd);
        chk("sleep power", 1'b1, pdn);
        auto_sleep = 1'b1;
        foreach (cm[j]) begin
            d = 24'($random(seed));
            fork
                host.xfer(8'h00, {20'h0_0000, cm[j]}, 2, rd);
                core(cm[j] == 4'h3 ? 1 : 3, d, 1'b0);
            join
            chk("decode", {cm[j] != 3, cm[j] == 3, 2'b00}, seen);
            d = 24'($random(seed));
            core(cm[j] == 4'h3 ? 1 : 3, d, 1'b0);
            rc = (rc + 2) % 4;
            host.xfer(8'h80, '0, 2, rd);
            chk("cont mode", {8'h00, rc[1:0], 2'b00, cm[j]}, rd);
            host.xfer(8'h00, '0, 2, rd);
            host.xfer(8'h81, '0, 3, rd);
            chk("cont result", d, rd);
        end
        conclude();
    end
endmodule : adc_mode_status_control_tb_top
